// ==== dv/dtp_top_properties.sv ====
// Bus and pin checker for the down timer pulse channel
`timescale 1ns/10ps
module dtp_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pulse_pb3_o,
  input wire logic pulse_pb3_oe_o,
  input wire logic pulse_pa4_o,
  input wire logic pulse_pa4_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_once_a: assert property (req_s |=> ack_s)
    else $error("ack not a single pulse");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
    else $error("read data outside ack");
  pin_copy_a: assert property (pulse_pb3_o == pulse_pa4_o)
    else $error("pins carry different waveforms");
  one_pin_a: assert property (!(pulse_pb3_oe_o && pulse_pa4_oe_o))
    else $error("both pins driven");
  pb_route_a: assert property (
    $changed(pulse_pb3_oe_o) |-> $past(wb_ack_o))
    else $error("pin drive changed without write");
  pa_route_a: assert property (
    $changed(pulse_pa4_oe_o) |-> $past(wb_ack_o))
    else $error("pin drive changed without write");
  irq_clear_a: assert property ($fell(irq_o) |->
    wb_ack_o || $past(wb_ack_o))
    else $error("irq fell without access");
endmodule
bind dtp_top dtp_top_properties dtp_top_properties_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pulse_pb3_o, .pulse_pb3_oe_o,
  .pulse_pa4_o, .pulse_pa4_oe_o, .irq_o);

// ==== dv/dtp_top_tb_top.sv ====
// Self-checking bench for the down timer pulse channel
`timescale 1ns/10ps
module dtp_top_tb_top;
  import dtp_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ext = 0;
  logic [3:0] adr = 0;
  logic [7:0] dat = 0, q, r, dato;
  logic ack, pb, pboe, pa, paoe, irq;
  int err_total = 0, n_tests = 0;
  always #20 clk_i = ~clk_i;
  dtp_top dtp_top_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(1'b1),
    .wb_dat_o(dato), .wb_ack_o(ack), .external_count_input_i(ext),
    .pulse_pb3_o(pb), .pulse_pb3_oe_o(pboe), .pulse_pa4_o(pa),
    .pulse_pa4_oe_o(paoe), .irq_o(irq));
  function automatic logic [7:0] hb_exp(input logic [1:0] h);
    return {2'b00, h, 4'h0};
  endfunction
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dato;
    cyc <= 0;
    stb <= 0;
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    test_done;
  end
  initial begin
    void'($urandom(32'h99c6));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, ADDR_CONTROL_ONE, 0); chk(q, CONTROL_ONE_RESET);
    wb(1, REG_COUNT, 8'hff);
    wb(0, REG_COUNT, 0); chk(q, 8'h00);
    repeat (4) begin
      r = 8'($urandom);
      wb(1, ADDR_HIGH_BITS, hb_exp(r[1:0]));
      wb(1, ADDR_COUNT_LOW, r);
      wb(0, ADDR_COUNT_LOW, 0); chk(q, r);
      wb(0, ADDR_HIGH_BITS, 0); chk(q, hb_exp(r[1:0]));
    end
    wb(1, ADDR_HIGH_BITS, 0);
    wb(1, ADDR_COUNT_LOW, 8'h05);
    for (int m = 0; m < 2; m++) begin
      wb(1, ADDR_CONTROL_ONE, {6'h0, m == 0, 1'b1});
      repeat (30) @(posedge clk_i);
      wb(0, ADDR_HIGH_BITS, 0); chk(q, hb_exp({2{m[0]}}));
    end
    wb(1, ADDR_CONTROL_ONE, 0);
    wb(0, ADDR_COUNT_LOW, 0);
    r = q;
    repeat (8) @(posedge clk_i);
    wb(0, ADDR_COUNT_LOW, 0); chk(q, r);
    wb(1, ADDR_CONTROL_ONE, 8'h06);
    wb(1, ADDR_IRQ_MASK, 0);
    wb(0, ADDR_IRQ_STATUS, 0);
    wb(1, ADDR_COUNT_LOW, 8'(($urandom % 16) + 1));
    wb(1, ADDR_CONTROL_ONE, 8'h07);
    repeat (40) @(posedge clk_i);
    wb(0, ADDR_COUNT_LOW, 0); chk(q, 8'h00);
    chk(8'(irq), 8'h00);
    wb(1, ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(8'(irq), 8'h01);
    wb(0, ADDR_IRQ_STATUS, 0); chk(q, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(8'(irq), 8'h00);
    wb(1, ADDR_CONTROL_ONE, 0);
    for (int e = 0; e < 2; e++) begin
      ext <= !e[0];
      wb(1, ADDR_CONTROL_TWO, {6'h0, e[0], 1'b1});
      wb(1, ADDR_COUNT_LOW, 8'h20);
      wb(1, ADDR_CONTROL_ONE, 8'h01);
      ext <= e[0];
      repeat (4) @(posedge clk_i);
      wb(0, ADDR_COUNT_LOW, 0); chk(q, 8'h20);
      ext <= !e[0];
      repeat (4) @(posedge clk_i);
      wb(0, ADDR_COUNT_LOW, 0); chk(q, 8'h1f);
      wb(1, ADDR_CONTROL_ONE, 0);
    end
    wb(1, ADDR_CONTROL_TWO, 0);
    wb(1, ADDR_COUNT_LOW, 0);
    wb(1, ADDR_DUTY_LOW, 8'h05);
    for (int p = 0; p < 2; p++) begin
      wb(1, ADDR_CONTROL_ONE, {1'b1, p[0], 6'h0});
      repeat (3) @(posedge clk_i);
      chk({pb, pboe, paoe}, {5'h0, !p[0], 2'b10});
    end
    wb(1, ADDR_CONTROL_TWO, 8'h04);
    repeat (3) @(posedge clk_i);
    chk({pa, pboe, paoe}, 8'h01);
    test_done;
  end
endmodule

// ==== rtl/dtp_pkg.sv ====
// Package with register map, field positions and reset values
package dtp_pkg;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h1;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h2;
  localparam logic [3:0] ADDR_DUTY_LOW = 4'h3;
  localparam logic [3:0] ADDR_HIGH_BITS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] REG_COUNT = 4'h7;
  localparam int BIT_RUN = 0;
  localparam int BIT_RELOAD_SEL = 1;
  localparam int BIT_SINGLE_SHOT = 2;
  localparam int BIT_POL_LOW = 6;
  localparam int BIT_ROUTE = 7;
  localparam int BIT_SRC_SEL = 0;
  localparam int BIT_EDGE_SEL = 1;
  localparam int BIT_ROUTE_PIN = 2;
  localparam int BIT_IRQ_UNDERFLOW = 0;
  localparam logic [9:0] COUNT_ALL_ONES = 10'h3ff;
  localparam logic [9:0] COUNT_ZERO = 10'h000;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [9:0] VALUE_RESET = 10'h000;
endpackage

// ==== rtl/dtp_regs.sv ====
// Register storage for the control, duty and reload bytes
`timescale 1ns/10ps
module dtp_regs
  import dtp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] control_one_o,
  output logic [7:0] control_two_o,
  output logic [9:0] reload_o,
  output logic [9:0] duty_o,
  output logic [7:0] mask_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_one_o <= CONTROL_ONE_RESET;
      control_two_o <= CONTROL_TWO_RESET;
      reload_o <= VALUE_RESET;
      duty_o <= VALUE_RESET;
      mask_o <= 8'h00;
    end else if (we_i) begin
      case (addr_i)
        ADDR_COUNT_LOW: reload_o[7:0] <= data_i;
        ADDR_CONTROL_ONE: control_one_o <= data_i & 8'hc7;
        ADDR_CONTROL_TWO: control_two_o <= data_i & 8'h07;
        ADDR_DUTY_LOW: duty_o[7:0] <= data_i;
        ADDR_HIGH_BITS: begin
          reload_o[9:8] <= data_i[5:4];
          duty_o[9:8] <= data_i[1:0];
        end
        ADDR_IRQ_MASK: mask_o <= data_i & 8'h01;
        default: ;
      endcase
    end
  end
endmodule

// ==== rtl/dtp_top.sv ====
// Down timer with one pulse channel behind a Wishbone slave
`timescale 1ns/10ps
module dtp_top
  import dtp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_input_i,
  output logic pulse_pb3_o,
  output logic pulse_pb3_oe_o,
  output logic pulse_pa4_o,
  output logic pulse_pa4_oe_o,
  output logic irq_o
);
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [9:0] reload;
  logic [9:0] duty;
  logic [7:0] mask;
  logic [9:0] count;
  logic [9:0] next_count;
  logic stopped;
  logic next_stopped;
  logic ext_prev;
  logic underflow;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] next_dat;

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i;
  wire bus_rd = bus_req && !wb_we_i;
  wire count_wr = bus_wr && (wb_adr_i == ADDR_COUNT_LOW);
  wire status_rd = bus_rd && (wb_adr_i == ADDR_IRQ_STATUS);

  dtp_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(bus_wr),
    .addr_i(wb_adr_i),
    .data_i(wb_dat_i),
    .control_one_o(control_one),
    .control_two_o(control_two),
    .reload_o(reload),
    .duty_o(duty),
    .mask_o(mask)
  );

  // Control fields
  wire run = control_one[BIT_RUN];
  wire reload_select = control_one[BIT_RELOAD_SEL];
  wire single_shot_select = control_one[BIT_SINGLE_SHOT];
  wire pulse_polarity_low = control_one[BIT_POL_LOW];
  wire pulse_out_route = control_one[BIT_ROUTE];
  wire count_source_select = control_two[BIT_SRC_SEL];
  wire count_edge_select = control_two[BIT_EDGE_SEL];
  wire route_to_pa4 = control_two[BIT_ROUTE_PIN];

  // Count tick from instruction clock or external edge
  wire ext_rise = external_count_input_i && !ext_prev;
  wire ext_fall = !external_count_input_i && ext_prev;
  wire ext_edge = count_edge_select ? ext_fall : ext_rise;
  wire tick = count_source_select ? ext_edge : 1'b1;
  wire step = run && tick && !stopped;
  wire at_zero = (count == COUNT_ZERO);
  wire [9:0] wrap_value = reload_select ? reload : COUNT_ALL_ONES;

  always_comb begin
    next_count = count;
    next_stopped = stopped;
    if (count_wr) begin
      next_count = {reload[9:8], wb_dat_i};
      next_stopped = 1'b0;
    end else if (step) begin
      if (!at_zero) begin
        next_count = count - 10'h001;
      end else if (single_shot_select) begin
        next_stopped = 1'b1;
      end else begin
        next_count = wrap_value;
      end
    end
    if (!run) begin
      next_stopped = count_wr ? 1'b0 : stopped;
    end
  end

  // Underflow pulse, one per count event at zero
  wire next_underflow = step && at_zero && !count_wr;

  // Sticky status, set wins over read clear
  always_comb begin
    next_status = status;
    if (status_rd) begin
      next_status = 8'h00;
    end
    if (underflow) begin
      next_status[BIT_IRQ_UNDERFLOW] = 1'b1;
    end
  end

  wire pulse_active = (count <= duty);
  wire pulse_level = pulse_active ^ pulse_polarity_low;

  // Read mux
  always_comb begin
    case (wb_adr_i)
      ADDR_COUNT_LOW: next_dat = count[7:0];
      ADDR_CONTROL_ONE: next_dat = control_one;
      ADDR_CONTROL_TWO: next_dat = control_two;
      ADDR_DUTY_LOW: next_dat = duty[7:0];
      ADDR_HIGH_BITS: next_dat = {2'b00, count[9:8], 2'b00, duty[9:8]};
      ADDR_IRQ_STATUS: next_dat = status;
      ADDR_IRQ_MASK: next_dat = mask;
      default: next_dat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= VALUE_RESET;
      stopped <= 1'b0;
      ext_prev <= 1'b0;
      underflow <= 1'b0;
      status <= 8'h00;
    end else begin
      count <= next_count;
      stopped <= next_stopped;
      ext_prev <= external_count_input_i;
      underflow <= next_underflow;
      status <= next_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? next_dat : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_pb3_o <= 1'b0;
      pulse_pb3_oe_o <= 1'b0;
      pulse_pa4_o <= 1'b0;
      pulse_pa4_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      pulse_pb3_o <= pulse_level;
      pulse_pb3_oe_o <= pulse_out_route && !route_to_pa4;
      pulse_pa4_o <= pulse_level;
      pulse_pa4_oe_o <= pulse_out_route && route_to_pa4;
      irq_o <= |(next_status & mask);
    end
  end
endmodule
